//--- rta_pkg.sv
// Purpose: shared constants and carriers for the clock alarm and indirect access block
// Assumes: 8-bit special-function-register port from the core, one clock domain
// Notes: timekeeping counters live outside and are presented as one struct
package rta_pkg;

  // special-function-register addresses
  localparam logic [7:0] RTA_ADDR_CONFIG = 8'ha1;
  localparam logic [7:0] RTA_ADDR_ENABLES = 8'ha2;
  localparam logic [7:0] RTA_ADDR_POINTER = 8'ha3;
  localparam logic [7:0] RTA_ADDR_DATA = 8'ha4;
  localparam logic [7:0] RTA_ADDR_KEY = 8'hc1;
  localparam logic [7:0] RTA_ADDR_NOM_TRIM = 8'hf6;
  localparam logic [7:0] RTA_ADDR_THERM_TRIM = 8'hf7;

  // field positions
  localparam int RTA_ALARM_FLAG_BIT = 6;
  localparam int RTA_DIR_BIT = 7;
  localparam int RTA_NUM_ALARMS = 5;
  localparam logic [7:0] RTA_UNLOCK_KEY = 8'hea;

  // indirect addresses of the timekeeping counters
  localparam logic [4:0] RTA_IA_HTHSEC = 5'h01;
  localparam logic [4:0] RTA_IA_SEC = 5'h02;
  localparam logic [4:0] RTA_IA_MIN = 5'h03;
  localparam logic [4:0] RTA_IA_HOUR = 5'h04;
  localparam logic [4:0] RTA_IA_DAY = 5'h05;
  localparam logic [4:0] RTA_IA_DATE = 5'h06;
  localparam logic [4:0] RTA_IA_MONTH = 5'h07;
  localparam logic [4:0] RTA_IA_YEAR = 5'h08;
  localparam logic [4:0] RTA_IA_INTVAL = 5'h09;
  // alarm values, index 0 = second .. 4 = date
  localparam logic [4:0] RTA_IA_ALARM_BASE = 5'h0a;
  localparam logic [4:0] RTA_IA_ALARM_LAST = 5'h0e;

  // reset values
  localparam logic [7:0] RTA_BYTE_RESET = 8'h00;
  localparam logic [4:0] RTA_ENABLES_RESET = 5'h00;
  localparam logic [4:0] RTA_PTR_ADDR_RESET = 5'h00;

  typedef struct packed {
    logic [7:0] hthsec;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
    logic [7:0] intval;
  } rta_time_type;

  typedef struct packed {
    logic wr;
    logic [4:0] addr;
    logic [7:0] data;
  } rta_tk_write_type;

endpackage

//--- rta_byte_reg.sv
// Purpose: one 8-bit holding register with write enable and synchronous clear
// Assumes: i_rst_n already synchronised to i_core_clk
// Notes: clear wins over write
`timescale 1ns/1ps
module rta_byte_reg
  import rta_pkg::*;
(
  input wire logic i_core_clk, // core clock
  input wire logic i_rst_n, // synchronised reset, active low
  input wire logic i_clear, // synchronous clear pulse
  input wire logic i_we, // write strobe
  input wire logic [7:0] i_d, // write data
  output logic [7:0] o_q // stored value
);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_q <= RTA_BYTE_RESET;
    end else if (i_clear) begin
      o_q <= RTA_BYTE_RESET;
    end else if (i_we) begin
      o_q <= i_d;
    end
  end

endmodule

//--- rta_top.sv
// Purpose: alarm match, indirect pointer/data access and compensation registers of the clock
// Assumes: core SFR strobes and time struct come from logic on i_core_clk
// Notes: counters are outside; their writes leave on o_tk_write
//
// Functional notes
// - date alarm compared with date counter when date enable bit 4 set.
// - weekday alarm compared with weekday counter when enable bit 3 set.
// - hour alarm compared with hour counter when enable bit 2 set.
// - minute alarm compared with minute counter when enable bit 1 set.
// - second alarm compared with seconds counter when enable bit 0 set.
// - alarm flag sets only when all enabled fields match together.
// - set alarm flag with clock interrupt enabled raises interrupt request.
// - direction 0 copies addressed internal register into the data register.
// - direction 1 writes data register into addressed internal register.
// - indirect write completes only when key 0xEA preceded the data write.
// - pointer holds 5-bit address, reset 0; bits 6 and 5 reserved.
// - 8-bit data register, reset 0, carries the byte read or written.
// - nominal compensation byte at 0xF6, reset 0.
// - temperature compensation byte at 0xF7, reset 0.
// - both compensation bytes cleared by watchdog, external or power-on reset.
// - alarm flag stays set until software clears it.
// - clearing direction bit triggers a read without stopping the clock.
`timescale 1ns/1ps
module rta_top
  import rta_pkg::*;
(
  input wire logic i_core_clk, // 50 MHz core clock
  input wire logic i_nrst, // power-on reset, active low, async
  input wire logic i_wdt_rst, // watchdog reset pulse
  input wire logic i_ext_rst, // external reset pulse
  input wire logic i_sfr_wr, // SFR write strobe
  input wire logic i_sfr_rd, // SFR read strobe
  input wire logic [7:0] i_sfr_addr, // SFR address
  input wire logic [7:0] i_sfr_wdata, // SFR write data
  output logic [7:0] o_sfr_rdata, // SFR read data, one cycle after i_sfr_rd
  input wire rta_time_type i_time, // current timekeeping counters
  input wire logic i_time_tick, // counters changed this cycle
  input wire logic i_clk_irq_en, // clock interrupt enable
  output logic o_clk_irq_req, // clock interrupt request
  output rta_tk_write_type o_tk_write, // indirect write to a counter
  output logic [7:0] o_nom_trim, // nominal compensation value
  output logic [7:0] o_therm_trim // temperature compensation value
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire wr_config = i_sfr_wr && (i_sfr_addr == RTA_ADDR_CONFIG);
  wire wr_enables = i_sfr_wr && (i_sfr_addr == RTA_ADDR_ENABLES);
  wire wr_pointer = i_sfr_wr && (i_sfr_addr == RTA_ADDR_POINTER);
  wire wr_data = i_sfr_wr && (i_sfr_addr == RTA_ADDR_DATA);
  wire wr_key = i_sfr_wr && (i_sfr_addr == RTA_ADDR_KEY);
  wire wr_nom = i_sfr_wr && (i_sfr_addr == RTA_ADDR_NOM_TRIM);
  wire wr_therm = i_sfr_wr && (i_sfr_addr == RTA_ADDR_THERM_TRIM);
  wire ptr_dir = i_sfr_wdata[RTA_DIR_BIT];
  wire [4:0] ptr_addr_in = i_sfr_wdata[4:0];
  wire trim_clear = i_wdt_rst || i_ext_rst;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [4:0] enables;
  logic ptr_dir_q;
  logic [4:0] ptr_addr;
  logic [7:0] data_q;
  logic key_open;
  logic write_armed;
  logic alarm_flag;
  logic [7:0] alarm_val [RTA_NUM_ALARMS];

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enables <= RTA_ENABLES_RESET;
    end else if (wr_enables) begin
      enables <= i_sfr_wdata[4:0];
    end
  end

  // reserved pointer bits are not stored and read as zero
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_dir_q <= 1'b0;
      ptr_addr <= RTA_PTR_ADDR_RESET;
    end else if (wr_pointer) begin
      ptr_dir_q <= ptr_dir;
      ptr_addr <= ptr_addr_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // key protection
  // the key covers exactly one following SFR write; only a data write turns it
  // into an armed indirect write, which the next pointer write may commit
  wire next_key_open = wr_key && (i_sfr_wdata == RTA_UNLOCK_KEY);
  wire arm_now = wr_data && key_open;
  wire commit_write = wr_pointer && ptr_dir && write_armed;
  wire next_write_armed = arm_now || (write_armed && !wr_pointer && !wr_data);

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      key_open <= 1'b0;
      write_armed <= 1'b0;
    end else begin
      if (i_sfr_wr) begin
        key_open <= next_key_open;
      end
      write_armed <= next_write_armed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indirect read mux, looked up on the address being written to the pointer
  wire in_alarm_range = (ptr_addr_in >= RTA_IA_ALARM_BASE) && (ptr_addr_in <= RTA_IA_ALARM_LAST);
  wire [4:0] alarm_idx_wide = ptr_addr_in - RTA_IA_ALARM_BASE;
  wire [2:0] alarm_idx = alarm_idx_wide[2:0];
  logic [7:0] ind_rd;

  always_comb begin
    ind_rd = RTA_BYTE_RESET;
    case (ptr_addr_in)
      RTA_IA_HTHSEC: ind_rd = i_time.hthsec;
      RTA_IA_SEC: ind_rd = i_time.sec;
      RTA_IA_MIN: ind_rd = i_time.min;
      RTA_IA_HOUR: ind_rd = i_time.hour;
      RTA_IA_DAY: ind_rd = i_time.day;
      RTA_IA_DATE: ind_rd = i_time.date;
      RTA_IA_MONTH: ind_rd = i_time.month;
      RTA_IA_YEAR: ind_rd = i_time.year;
      RTA_IA_INTVAL: ind_rd = i_time.intval;
      default: begin
        if (in_alarm_range) begin
          ind_rd = alarm_val[alarm_idx];
        end
      end
    endcase
  end

  // counters keep running: the read is a snapshot, nothing is paused
  wire start_read = wr_pointer && !ptr_dir;

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= RTA_BYTE_RESET;
    end else if (start_read) begin
      data_q <= ind_rd;
    end else if (wr_data) begin
      data_q <= i_sfr_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indirect write: alarm values here, counters outside
  wire commit_alarm = commit_write && in_alarm_range;
  wire commit_counter = commit_write && (ptr_addr_in >= RTA_IA_HTHSEC) && (ptr_addr_in <= RTA_IA_INTVAL);

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_tk_write <= '0;
    end else begin
      o_tk_write.wr <= commit_counter;
      o_tk_write.addr <= ptr_addr_in;
      o_tk_write.data <= data_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < RTA_NUM_ALARMS; gi++) begin : g_alarm
      rta_byte_reg u_alarm (
        .i_core_clk(i_core_clk),
        .i_rst_n(rst_n),
        .i_clear(1'b0),
        .i_we(commit_alarm && (alarm_idx == 3'(gi))),
        .i_d(data_q),
        .o_q(alarm_val[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // compensation bytes
  rta_byte_reg u_nom_trim (
    .i_core_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_clear(trim_clear),
    .i_we(wr_nom),
    .i_d(i_sfr_wdata),
    .o_q(o_nom_trim)
  );

  rta_byte_reg u_therm_trim (
    .i_core_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_clear(trim_clear),
    .i_we(wr_therm),
    .i_d(i_sfr_wdata),
    .o_q(o_therm_trim)
  );

  ////////////////////////////////////////////////////////////////////////////
  // alarm match
  wire match_sec = !enables[0] || (alarm_val[0] == i_time.sec);
  wire match_min = !enables[1] || (alarm_val[1] == i_time.min);
  wire match_hour = !enables[2] || (alarm_val[2] == i_time.hour);
  wire match_day = !enables[3] || (alarm_val[3] == i_time.day);
  wire match_date = !enables[4] || (alarm_val[4] == i_time.date);
  // with no field enabled the match would be true every tick, so it never fires
  wire all_match = (|enables) && match_sec && match_min && match_hour && match_day && match_date;
  wire alarm_set = i_time_tick && all_match;
  wire alarm_clr = wr_config && !i_sfr_wdata[RTA_ALARM_FLAG_BIT];
  // a match in the clearing cycle keeps the flag set
  wire next_alarm_flag = alarm_set || (alarm_flag && !alarm_clr);

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_flag <= 1'b0;
    end else begin
      alarm_flag <= next_alarm_flag;
    end
  end

  assign o_clk_irq_req = alarm_flag && i_clk_irq_en;

  ////////////////////////////////////////////////////////////////////////////
  // SFR read port
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = RTA_BYTE_RESET;
    case (i_sfr_addr)
      RTA_ADDR_CONFIG: rd_mux = {1'b0, alarm_flag, 6'h00};
      RTA_ADDR_ENABLES: rd_mux = {3'h0, enables};
      RTA_ADDR_POINTER: rd_mux = {ptr_dir_q, 2'h0, ptr_addr};
      RTA_ADDR_DATA: rd_mux = data_q;
      RTA_ADDR_NOM_TRIM: rd_mux = o_nom_trim;
      RTA_ADDR_THERM_TRIM: rd_mux = o_therm_trim;
      default: rd_mux = RTA_BYTE_RESET;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_sfr_rdata <= RTA_BYTE_RESET;
    end else if (i_sfr_rd) begin
      o_sfr_rdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!rst_n);

  property p_date_gate;
    i_time_tick && enables[4] && (alarm_val[4] != i_time.date) |-> !alarm_set;
  endproperty
  a_date_gate: assert property (p_date_gate) else $error("date mismatch set alarm");

  property p_day_gate;
    i_time_tick && enables[3] && (alarm_val[3] != i_time.day) |-> !alarm_set;
  endproperty
  a_day_gate: assert property (p_day_gate) else $error("weekday mismatch set alarm");

  property p_hour_gate;
    i_time_tick && enables[2] && (alarm_val[2] != i_time.hour) |-> !alarm_set;
  endproperty
  a_hour_gate: assert property (p_hour_gate) else $error("hour mismatch set alarm");

  property p_min_gate;
    i_time_tick && enables[1] && (alarm_val[1] != i_time.min) |-> !alarm_set;
  endproperty
  a_min_gate: assert property (p_min_gate) else $error("minute mismatch set alarm");

  property p_sec_gate;
    i_time_tick && enables[0] && (alarm_val[0] != i_time.sec) |-> !alarm_set;
  endproperty
  a_sec_gate: assert property (p_sec_gate) else $error("second mismatch set alarm");

  property p_flag_sets;
    i_time_tick && (enables != 5'h00) && match_sec && match_min && match_hour && match_day && match_date
      |=> alarm_flag;
  endproperty
  a_flag_sets: assert property (p_flag_sets) else $error("full match did not set flag");

  // request must follow the set edge while the enable stays up
  property p_irq;
    alarm_set && i_clk_irq_en ##1 i_clk_irq_en |-> o_clk_irq_req;
  endproperty
  a_irq: assert property (p_irq) else $error("flag with enable gave no request");

  property p_read_copy;
    wr_pointer && !ptr_dir && (ptr_addr_in == RTA_IA_SEC) |=> data_q == $past(i_time.sec);
  endproperty
  a_read_copy: assert property (p_read_copy) else $error("read did not copy seconds");

  sequence s_unlocked_data;
    wr_key && (i_sfr_wdata == RTA_UNLOCK_KEY) ##1 (i_sfr_wr [*1]) ##0 wr_data;
  endsequence

  sequence s_commit_ptr;
    wr_pointer && ptr_dir && (ptr_addr_in == RTA_IA_ALARM_BASE);
  endsequence

  property p_write_commits;
    s_unlocked_data ##1 s_commit_ptr |=> alarm_val[0] == $past(data_q);
  endproperty
  a_write_commits: assert property (p_write_commits) else $error("keyed write not committed");

  property p_counter_write;
    commit_counter |=> o_tk_write.wr && (o_tk_write.data == $past(data_q)) && (o_tk_write.addr == $past(ptr_addr_in));
  endproperty
  a_counter_write: assert property (p_counter_write) else $error("counter write not issued");

  property p_no_key_no_write;
    wr_pointer && ptr_dir && !write_armed |=> !o_tk_write.wr && $stable(alarm_val[0]);
  endproperty
  a_no_key_no_write: assert property (p_no_key_no_write) else $error("write without key");

  property p_key_lapses;
    wr_key && (i_sfr_wdata == RTA_UNLOCK_KEY) ##1 (i_sfr_wr && !wr_data) |=> !write_armed;
  endproperty
  a_key_lapses: assert property (p_key_lapses) else $error("key survived foreign write");

  property p_trim_clear;
    trim_clear |=> (o_nom_trim == 8'h00) && (o_therm_trim == 8'h00);
  endproperty
  a_trim_clear: assert property (p_trim_clear) else $error("trim not cleared by reset");

  property p_flag_holds;
    alarm_flag && !alarm_clr |=> alarm_flag;
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("alarm flag dropped");

  property p_no_tick_no_set;
    !alarm_flag && !i_time_tick |=> !alarm_flag;
  endproperty
  a_no_tick_no_set: assert property (p_no_tick_no_set) else $error("flag set without tick");

endmodule

//--- rta_tk_model.sv
// Purpose: stand-in for the timekeeping counters that sit behind the indirect path
// Assumes: same clock as the block; the bench loads new counter values
// Notes: tick only on a bench load, so an indirect counter write never fires the alarm
`timescale 1ns/1ps
module rta_tk_model
  import rta_pkg::*;
(
  input wire logic i_core_clk, // core clock
  input wire logic i_rst_n, // reset, active low
  input wire logic i_load, // load new counter values
  input wire rta_time_type i_load_val, // values to load
  input wire rta_tk_write_type i_tk_write, // indirect write from the block
  output rta_time_type o_time, // counters
  output logic o_tick // counters changed this cycle
);
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_time <= '0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= i_load;
      if (i_load) begin
        o_time <= i_load_val;
      end else if (i_tk_write.wr && i_tk_write.addr >= 5'h01 && i_tk_write.addr <= 5'h09) begin
        // hthsec sits in the top byte, so address 1 is the highest slice
        o_time[8 * (9 - int'(i_tk_write.addr)) +: 8] <= i_tk_write.data;
      end
    end
  end
endmodule

//--- rta_top_tb.sv
// Purpose: self-checking bench for alarm match, indirect access and trim registers
// Assumes: inputs driven at the falling edge, one access strobe held per rising edge
// Notes: alarm expectations come from fixed alarm values 0x20..0x24 at 0x0a..0x0e
`timescale 1ns/1ps
module rta_top_tb;
  import rta_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_wdt_rst = 1'b0;
  logic i_ext_rst = 1'b0;
  logic i_sfr_wr = 1'b0;
  logic i_sfr_rd = 1'b0;
  logic [7:0] i_sfr_addr = 8'h00;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic i_clk_irq_en = 1'b0;
  logic load = 1'b0;
  rta_time_type load_val = '0;
  rta_time_type cnt_time;
  logic tick;
  logic [7:0] o_sfr_rdata;
  logic o_clk_irq_req;
  rta_tk_write_type o_tk_write;
  logic [7:0] o_nom_trim;
  logic [7:0] o_therm_trim;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #10 i_core_clk = ~i_core_clk;

  rta_top DUT (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_wdt_rst(i_wdt_rst), .i_ext_rst(i_ext_rst),
    .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd), .i_sfr_addr(i_sfr_addr), .i_sfr_wdata(i_sfr_wdata),
    .o_sfr_rdata(o_sfr_rdata), .i_time(cnt_time), .i_time_tick(tick), .i_clk_irq_en(i_clk_irq_en),
    .o_clk_irq_req(o_clk_irq_req), .o_tk_write(o_tk_write), .o_nom_trim(o_nom_trim),
    .o_therm_trim(o_therm_trim));

  rta_tk_model tk (.i_core_clk(i_core_clk), .i_rst_n(i_nrst), .i_load(load), .i_load_val(load_val),
    .i_tk_write(o_tk_write), .o_time(cnt_time), .o_tick(tick));

  //////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      $display("[FAIL] %0t ns: run did not finish in time", $time);
      report_and_stop();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // strobe held exactly one rising edge; the next task drops or replaces it
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    i_sfr_wr = w;
    i_sfr_rd = ~w;
    i_sfr_addr = a;
    i_sfr_wdata = d;
    @(posedge i_core_clk);
  endtask

  task automatic put(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic get(input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    #1;
    check(o_sfr_rdata, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(negedge i_core_clk);
      i_sfr_wr = 1'b0;
      i_sfr_rd = 1'b0;
    end
  endtask

  task automatic iwr(input logic [4:0] ia, input logic [7:0] d);
    put(RTA_ADDR_KEY, RTA_UNLOCK_KEY);
    put(RTA_ADDR_DATA, d);
    put(RTA_ADDR_POINTER, {3'b100, ia});
  endtask

  task automatic ird(input logic [4:0] ia, input logic [7:0] exp);
    put(RTA_ADDR_POINTER, {3'b000, ia});
    get(RTA_ADDR_DATA, exp);
  endtask

  task automatic set_time(input rta_time_type v);
    @(negedge i_core_clk);
    i_sfr_wr = 1'b0;
    i_sfr_rd = 1'b0;
    load = 1'b1;
    load_val = v;
    @(negedge i_core_clk);
    load = 1'b0;
  endtask

  task automatic pulse(input logic ext);
    @(negedge i_core_clk);
    i_sfr_wr = 1'b0;
    i_sfr_rd = 1'b0;
    i_ext_rst = ext;
    i_wdt_rst = ~ext;
    @(negedge i_core_clk);
    i_ext_rst = 1'b0;
    i_wdt_rst = 1'b0;
  endtask

  // fields in the mask equal their alarm values, the rest never do
  function automatic rta_time_type mk(input logic [4:0] m);
    rta_time_type t;
    t = '0;
    t.sec = m[0] ? 8'h20 : 8'h01;
    t.min = m[1] ? 8'h21 : 8'h01;
    t.hour = m[2] ? 8'h22 : 8'h01;
    t.day = m[3] ? 8'h23 : 8'h01;
    t.date = m[4] ? 8'h24 : 8'h01;
    return t;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_nrst = 1'b1;
    repeat (3) @(posedge i_core_clk);
    get(RTA_ADDR_CONFIG, 8'h00);
    get(RTA_ADDR_ENABLES, 8'h00);
    get(RTA_ADDR_POINTER, 8'h00);
    get(RTA_ADDR_DATA, 8'h00);
    get(RTA_ADDR_NOM_TRIM, 8'h00);
    get(RTA_ADDR_THERM_TRIM, 8'h00);
    get(8'h80, 8'h00);
    $display("test reset_values done");
    put(RTA_ADDR_NOM_TRIM, 8'ha5);
    put(RTA_ADDR_THERM_TRIM, 8'h3c);
    get(RTA_ADDR_NOM_TRIM, 8'ha5);
    get(RTA_ADDR_THERM_TRIM, 8'h3c);
    pulse(1'b0);
    check(o_nom_trim, 8'h00);
    check(o_therm_trim, 8'h00);
    put(RTA_ADDR_NOM_TRIM, 8'h5a);
    put(RTA_ADDR_THERM_TRIM, 8'hc3);
    pulse(1'b1);
    check(o_nom_trim, 8'h00);
    check(o_therm_trim, 8'h00);
    $display("test trims done");
    set_time(rta_time_type'(72'h112233445566778899));
    for (int k = 1; k <= 9; k++) begin
      ird(5'(k), 8'(k * 17));
    end
    put(RTA_ADDR_POINTER, 8'h63);
    get(RTA_ADDR_POINTER, 8'h03);
    get(RTA_ADDR_DATA, 8'h33);
    $display("test indirect_read done");
    for (int i = 0; i < 5; i++) begin
      iwr(5'(10 + i), 8'(32 + i));
    end
    for (int i = 0; i < 5; i++) begin
      ird(5'(10 + i), 8'(32 + i));
    end
    iwr(RTA_IA_MIN, 8'h30);
    #1;
    check({7'h00, o_tk_write.wr}, 8'h01);
    check({3'h0, o_tk_write.addr}, {3'h0, RTA_IA_MIN});
    check(o_tk_write.data, 8'h30);
    idle(2);
    check({7'h00, o_tk_write.wr}, 8'h00);
    ird(RTA_IA_MIN, 8'h30);
    put(RTA_ADDR_DATA, 8'h55);
    put(RTA_ADDR_POINTER, 8'h8a);
    ird(5'h0a, 8'h20);
    put(RTA_ADDR_KEY, RTA_UNLOCK_KEY);
    put(RTA_ADDR_NOM_TRIM, 8'h11);
    put(RTA_ADDR_DATA, 8'h55);
    put(RTA_ADDR_POINTER, 8'h8a);
    ird(5'h0a, 8'h20);
    $display("test indirect_write done");
    i_clk_irq_en = 1'b1;
    for (int i = 0; i < 5; i++) begin
      put(RTA_ADDR_ENABLES, 8'(1 << i));
      put(RTA_ADDR_CONFIG, 8'h00);
      set_time(mk(5'(1 << i)));
      get(RTA_ADDR_CONFIG, 8'h40);
      check({7'h00, o_clk_irq_req}, 8'h01);
      put(RTA_ADDR_CONFIG, 8'h00);
      set_time(mk(~5'(1 << i)));
      get(RTA_ADDR_CONFIG, 8'h00);
    end
    put(RTA_ADDR_ENABLES, 8'hff);
    get(RTA_ADDR_ENABLES, 8'h1f);
    set_time(mk(5'h0f));
    get(RTA_ADDR_CONFIG, 8'h00);
    set_time(mk(5'h1f));
    get(RTA_ADDR_CONFIG, 8'h40);
    set_time(mk(5'h00));
    put(RTA_ADDR_CONFIG, 8'h40);
    get(RTA_ADDR_CONFIG, 8'h40);
    @(negedge i_core_clk);
    i_clk_irq_en = 1'b0;
    i_sfr_rd = 1'b0;
    #1;
    check({7'h00, o_clk_irq_req}, 8'h00);
    put(RTA_ADDR_CONFIG, 8'h00);
    get(RTA_ADDR_CONFIG, 8'h00);
    set_time(mk(5'h1f));
    put(RTA_ADDR_CONFIG, 8'h00);
    idle(4);
    get(RTA_ADDR_CONFIG, 8'h00);
    $display("test alarm done");
    put(RTA_ADDR_NOM_TRIM, 8'h77);
    idle(1);
    i_nrst = 1'b0;
    @(negedge i_core_clk);
    check(o_nom_trim, 8'h00);
    i_nrst = 1'b1;
    repeat (3) @(posedge i_core_clk);
    get(RTA_ADDR_NOM_TRIM, 8'h00);
    $display("test power_on_reset done");
    report_and_stop();
  end
endmodule
